// file: logic/gmii_frame_consts.vh
`ifndef GMII_FRAME_CONSTS_VH
`define GMII_FRAME_CONSTS_VH

// Octet codes on the data bundles, first serial bit in bit 0
`define GMII_PREAMBLE_OCTET   8'h55
`define GMII_SFD_OCTET        8'hD5
`define GMII_IDLE_OCTET       8'h00
`define GMII_FALSE_CARRIER    8'h0E
`define GMII_EXTEND_OCTET     8'h0F
`define GMII_EXTEND_ERR_OCTET 8'h1F

// Frame layout counts, in octets
`define GMII_PREAMBLE_LEN     8'h07
`define GMII_IFG_OCTETS       8'h0C
`define GMII_JAM_OCTETS       8'h04

// Timing figures in bit times; one 4 ns clk_sys cycle lasts 4 bit times
`define GMII_BITS_PER_CYC     4
`define GMII_DETECT_MAX_BITS  48
`define GMII_RESPONSE_MAX_BITS 112
`define GMII_SKEW_MAX_BITS    16
`define GMII_DETECT_MAX_CYC   (`GMII_DETECT_MAX_BITS / `GMII_BITS_PER_CYC)
`define GMII_RESPONSE_MAX_CYC (`GMII_RESPONSE_MAX_BITS / `GMII_BITS_PER_CYC)
`define GMII_SKEW_MAX_CYC     (`GMII_SKEW_MAX_BITS / `GMII_BITS_PER_CYC)

`endif

// file: logic/gmii_tx_fifo.v
`timescale 1ns/10ps
`default_nettype none

module gmii_tx_fifo
#(
   parameter WIDTH = 9,
   parameter DEPTH = 4,
   parameter AW    = 2
)
(
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg  [AW:0]      wr_ptr_ff;
   reg  [AW:0]      rd_ptr_ff;
   wire             push;
   wire             pop;
   wire             full;
   wire             empty;

   assign empty     = (wr_ptr_ff == rd_ptr_ff);
   assign full      = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) &&
                      (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;
   assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr_ff <= {(AW+1){1'b0}};
         rd_ptr_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (pop)
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end

   // Storage needs no reset; out_data is only meaningful while out_valid
   always @(posedge clk_sys)
   begin
      if (push)
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
   end

endmodule // gmii_tx_fifo

`default_nettype wire

// file: logic/gmii_frame_stream.v
`timescale 1ns/10ps
`default_nettype none
`include "gmii_frame_consts.vh"

// How it works
// R1: PHY idles with valid low, error low/zero
// R2: Transmit enable and error low when idle
// R3: Burst gaps filled with extend, enable low
// R4: PHY signals extend between received burst frames
// R5: Spacing from enable fall, or carrier fall
// R6: Seven preamble octets then start delimiter
// R7: First serial bit is bit 0
// R8: Preamble starts with first enable cycle
// R9: Accept delimiter as first valid octet
// R10: Accept zero to seven preamble octets
// R11: Frame data carried as whole octets
// R12: Falling framing signal ends the frame
// R13: Carrier extend: error high, enable low
// R14: Receiver never requires carrier extension
// R15: Packet start/end on valid edges
// R16: Transmit start to enable within 48 bits
// R17: Carrier detect within 48 bit times
// R18: Carrier detect skew at most 16 bits
// R19: Enable within 112 bits of carrier
// R20: Collision detect within 48 bit times
// R21: First jam octet within 112 bits
// R22: Extend, extend error, false carrier codes
// R23: PHY flags errors with error during valid
// R24: Bit limits divided by four give cycles
module gmii_frame_stream
#(
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW    = 2,
   parameter JAM_OCTET  = 8'h99
)
(
   input  wire       clk_sys,
   input  wire       reset_n,
   // Transmit user side
   input  wire       tx_valid,
   output wire       tx_ready,
   input  wire [7:0] tx_data,
   input  wire       tx_last,
   input  wire       burst_en,
   input  wire [7:0] ext_octets,
   output wire       tx_busy,
   output wire       tx_collided,
   // Transmit link side
   output wire       gtx_clk,
   output wire [7:0] txd,
   output wire       tx_en,
   output wire       tx_er,
   // Receive link side
   input  wire       rx_clk,
   input  wire [7:0] rxd,
   input  wire       rx_dv,
   input  wire       rx_er,
   input  wire       crs,
   input  wire       col,
   // Receive user side
   output wire [7:0] rx_data,
   output wire       rx_valid,
   output wire       rx_data_err,
   output wire       rx_sop,
   output wire       rx_eop,
   output wire       rx_frame_bad,
   output wire       rx_extend,
   output wire       rx_extend_err,
   output wire       rx_false_carrier,
   output wire       carrier_sense,
   output wire       collision
);

   localparam [6:0] TX_IDLE = 7'b000_0001;
   localparam [6:0] TX_PRE  = 7'b000_0010;
   localparam [6:0] TX_SFD  = 7'b000_0100;
   localparam [6:0] TX_DATA = 7'b000_1000;
   localparam [6:0] TX_EXT  = 7'b001_0000;
   localparam [6:0] TX_GAP  = 7'b010_0000;
   localparam [6:0] TX_JAM  = 7'b100_0000;

   localparam [2:0] RX_IDLE = 3'b001;
   localparam [2:0] RX_PRE  = 3'b010;
   localparam [2:0] RX_DATA = 3'b100;

   // Pin synchronisers: stage 1 is read only by stage 2
   reg  [12:0] sync1_ff;
   reg  [12:0] sync2_ff;
   reg         rx_clk_d_ff;
   wire        rx_clk_s;
   wire        crs_s;
   wire        col_s;
   wire        rx_dv_s;
   wire        rx_er_s;
   wire [7:0]  rxd_s;
   wire        rx_tick;

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_ff    <= 13'h0000;
         sync2_ff    <= 13'h0000;
         rx_clk_d_ff <= 1'b0;
      end
      else
      begin
         sync1_ff    <= {rx_clk, crs, col, rx_dv, rx_er, rxd};
         sync2_ff    <= sync1_ff;
         rx_clk_d_ff <= rx_clk_s;
      end
   end

   // Two stages of 4 ns keep detection far inside 48 bit times [R17] [R20] [R24]
   // Assert and deassert take the same path, so their delays match [R18]
   assign rx_clk_s = sync2_ff[12];
   assign crs_s    = sync2_ff[11];
   assign col_s    = sync2_ff[10];
   assign rx_dv_s  = sync2_ff[9];
   assign rx_er_s  = sync2_ff[8];
   assign rxd_s    = sync2_ff[7:0];
   assign rx_tick  = rx_clk_s && !rx_clk_d_ff;

   assign carrier_sense = crs_s; // [R17]
   assign collision     = col_s; // [R20]

   // Transmit FIFO
   wire       fifo_valid;
   reg        fifo_pop;
   wire [8:0] fifo_word;

   gmii_tx_fifo
   #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   )
   u_tx_fifo
   (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   ({tx_last, tx_data}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_word)
   );

   // Transmit clock is clk_sys divided by two; outputs change as it falls
   reg        gtx_ff;
   wire       tx_tick;

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         gtx_ff <= 1'b0;
      else
         gtx_ff <= !gtx_ff;
   end

   assign gtx_clk = gtx_ff;
   assign tx_tick = gtx_ff;

   reg [6:0] tx_st_ff;
   reg [6:0] nxt_tx_st;
   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   reg [7:0] ifg_ff;
   reg [7:0] nxt_ifg;
   reg       drop_ff;
   reg       nxt_drop;
   reg [7:0] txd_ff;
   reg [7:0] nxt_txd;
   reg       tx_en_ff;
   reg       nxt_tx_en;
   reg       tx_er_ff;
   reg       nxt_tx_er;
   reg       coll_ff;
   reg       nxt_coll;
   wire      ifg_done;
   wire      in_frame;

   assign ifg_done = (ifg_ff >= `GMII_IFG_OCTETS);
   assign in_frame = (tx_st_ff == TX_PRE) || (tx_st_ff == TX_SFD) || (tx_st_ff == TX_DATA);

   always @*
   begin
      nxt_tx_st = tx_st_ff;
      nxt_cnt   = cnt_ff;
      nxt_ifg   = ifg_ff;
      nxt_drop  = drop_ff;
      nxt_txd   = `GMII_IDLE_OCTET;
      nxt_tx_en = 1'b0;
      nxt_tx_er = 1'b0; // [R2]
      nxt_coll  = 1'b0;
      fifo_pop  = 1'b0;
      // Remainder of a jammed frame is discarded at full clk_sys rate
      if (drop_ff && fifo_valid)
      begin
         fifo_pop = 1'b1;
         if (fifo_word[8])
            nxt_drop = 1'b0;
      end
      if (tx_tick)
      begin
         if (col_s && in_frame)
         begin
            // Jam follows the detected collision on the next octet [R21]
            nxt_tx_st = TX_JAM;
            nxt_cnt   = `GMII_JAM_OCTETS - 8'h01;
            nxt_txd   = JAM_OCTET;
            nxt_tx_en = 1'b1;
            nxt_coll  = 1'b1;
            nxt_drop  = (tx_st_ff != TX_DATA) || !(fifo_valid && fifo_word[8]);
            fifo_pop  = (tx_st_ff == TX_DATA) && fifo_valid;
         end
         else
         begin
            case (tx_st_ff)
               TX_IDLE:
               begin
                  // Between bursts spacing counts from carrier falling [R5]
                  if (crs_s && !ifg_done)
                     nxt_ifg = 8'h00;
                  else if (!ifg_done)
                     nxt_ifg = ifg_ff + 8'h01;
                  // Start within one octet of the decision [R16] [R19]
                  if (fifo_valid && !drop_ff && ifg_done)
                  begin
                     nxt_tx_st = TX_PRE;
                     nxt_cnt   = `GMII_PREAMBLE_LEN - 8'h01; // [R6]
                     nxt_txd   = `GMII_PREAMBLE_OCTET; // [R8] [R7]
                     nxt_tx_en = 1'b1;
                  end
               end
               TX_PRE:
               begin
                  nxt_tx_en = 1'b1;
                  if (cnt_ff == 8'h00)
                  begin
                     nxt_tx_st = TX_SFD;
                     nxt_txd   = `GMII_SFD_OCTET; // [R6] [R7]
                  end
                  else
                  begin
                     nxt_cnt = cnt_ff - 8'h01;
                     nxt_txd = `GMII_PREAMBLE_OCTET; // [R6]
                  end
               end
               TX_SFD, TX_DATA:
               begin
                  if (fifo_valid)
                  begin
                     // One whole octet per transmit clock [R11]
                     fifo_pop  = 1'b1;
                     nxt_tx_st = fifo_word[8] ? TX_EXT : TX_DATA;
                     nxt_txd   = fifo_word[7:0];
                     nxt_tx_en = 1'b1;
                     nxt_cnt   = 8'h00;
                  end
                  else
                  begin
                     // Underrun: mark the octet bad and close the frame
                     nxt_tx_st = TX_EXT;
                     nxt_tx_en = 1'b1;
                     nxt_tx_er = 1'b1;
                     nxt_txd   = 8'h00;
                     nxt_cnt   = 8'h00;
                     nxt_drop  = 1'b1;
                  end
               end
               TX_EXT:
               begin
                  // Enable has fallen; that edge ends the frame [R12]
                  if (cnt_ff < ext_octets)
                  begin
                     nxt_cnt   = cnt_ff + 8'h01;
                     nxt_txd   = `GMII_EXTEND_OCTET; // [R13]
                     nxt_tx_er = 1'b1;
                  end
                  else if (burst_en && fifo_valid && !drop_ff)
                  begin
                     nxt_tx_st = TX_GAP;
                     nxt_ifg   = 8'h01; // [R5]
                     nxt_txd   = `GMII_EXTEND_OCTET; // [R3]
                     nxt_tx_er = 1'b1;
                  end
                  else
                  begin
                     nxt_tx_st = TX_IDLE;
                     nxt_ifg   = 8'h00;
                  end
               end
               TX_GAP:
               begin
                  if (ifg_done)
                  begin
                     nxt_tx_st = TX_PRE;
                     nxt_cnt   = `GMII_PREAMBLE_LEN - 8'h01; // [R6]
                     nxt_txd   = `GMII_PREAMBLE_OCTET;
                     nxt_tx_en = 1'b1;
                  end
                  else
                  begin
                     // Gap inside a burst is carrier extend, enable low [R3]
                     nxt_ifg   = ifg_ff + 8'h01; // [R5]
                     nxt_txd   = `GMII_EXTEND_OCTET;
                     nxt_tx_er = 1'b1;
                  end
               end
               TX_JAM:
               begin
                  if (cnt_ff == 8'h00)
                  begin
                     nxt_tx_st = TX_IDLE;
                     nxt_ifg   = 8'h00;
                  end
                  else
                  begin
                     nxt_cnt   = cnt_ff - 8'h01;
                     nxt_txd   = JAM_OCTET;
                     nxt_tx_en = 1'b1;
                  end
               end
               default:
               begin
                  nxt_tx_st = TX_IDLE;
               end
            endcase
         end
      end
      else
      begin
         nxt_txd   = txd_ff;
         nxt_tx_en = tx_en_ff;
         nxt_tx_er = tx_er_ff;
      end
   end

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_st_ff <= TX_IDLE;
         cnt_ff   <= 8'h00;
         ifg_ff   <= 8'h00;
         drop_ff  <= 1'b0;
         txd_ff   <= 8'h00;
         tx_en_ff <= 1'b0;
         tx_er_ff <= 1'b0;
         coll_ff  <= 1'b0;
      end
      else
      begin
         tx_st_ff <= nxt_tx_st;
         cnt_ff   <= nxt_cnt;
         ifg_ff   <= nxt_ifg;
         drop_ff  <= nxt_drop;
         txd_ff   <= nxt_txd;
         tx_en_ff <= nxt_tx_en;
         tx_er_ff <= nxt_tx_er;
         coll_ff  <= nxt_coll;
      end
   end

   assign txd         = txd_ff;
   assign tx_en       = tx_en_ff;
   assign tx_er       = tx_er_ff;
   assign tx_busy     = (tx_st_ff != TX_IDLE);
   assign tx_collided = coll_ff;

   // Receive path, one octet per rising receive clock
   reg [2:0] rx_st_ff;
   reg [7:0] rx_data_ff;
   reg       rx_valid_ff;
   reg       rx_derr_ff;
   reg       rx_sop_ff;
   reg       rx_eop_ff;
   reg       rx_bad_ff;
   reg       rx_ext_ff;
   reg       rx_exterr_ff;
   reg       rx_fc_ff;
   reg       dv_d_ff;
   reg       err_seen_ff;
   wire      rx_code;

   // Idle (valid low, error low or octet zero) needs no action [R1]
   assign rx_code = rx_tick && !rx_dv_s && rx_er_s;

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_st_ff     <= RX_IDLE;
         rx_data_ff   <= 8'h00;
         rx_valid_ff  <= 1'b0;
         rx_derr_ff   <= 1'b0;
         rx_sop_ff    <= 1'b0;
         rx_eop_ff    <= 1'b0;
         rx_bad_ff    <= 1'b0;
         rx_ext_ff    <= 1'b0;
         rx_exterr_ff <= 1'b0;
         rx_fc_ff     <= 1'b0;
         dv_d_ff      <= 1'b0;
         err_seen_ff  <= 1'b0;
      end
      else
      begin
         rx_valid_ff  <= 1'b0;
         rx_sop_ff    <= 1'b0;
         rx_eop_ff    <= 1'b0;
         rx_bad_ff    <= 1'b0;
         rx_exterr_ff <= 1'b0;
         rx_fc_ff     <= 1'b0;
         if (rx_tick)
         begin
            dv_d_ff   <= rx_dv_s;
            rx_ext_ff <= 1'b0;
            // Packet start on valid rising, end on valid falling [R15]
            rx_sop_ff <= rx_dv_s && !dv_d_ff;
            if (!rx_dv_s && dv_d_ff)
            begin
               // Valid falling closes the frame, extension or not [R12] [R14]
               rx_eop_ff   <= 1'b1;
               rx_bad_ff   <= err_seen_ff || (rx_st_ff != RX_DATA);
               rx_st_ff    <= RX_IDLE;
               err_seen_ff <= 1'b0;
            end
            else if (rx_dv_s)
            begin
               // Error during valid taints the frame [R23]
               if (rx_er_s)
                  err_seen_ff <= 1'b1;
               case (rx_st_ff)
                  RX_IDLE, RX_PRE:
                  begin
                     // Delimiter may come after any shrunken preamble [R9] [R10]
                     if (rxd_s == `GMII_SFD_OCTET)
                        rx_st_ff <= RX_DATA;
                     else
                        rx_st_ff <= RX_PRE;
                  end
                  RX_DATA:
                  begin
                     rx_data_ff  <= rxd_s; // [R11]
                     rx_valid_ff <= 1'b1;
                     rx_derr_ff  <= rx_er_s;
                  end
                  default:
                  begin
                     rx_st_ff <= RX_IDLE;
                  end
               endcase
            end
            if (rx_code)
            begin
               // Codes carried with valid low and error high [R22] [R4]
               rx_ext_ff    <= (rxd_s == `GMII_EXTEND_OCTET);
               rx_exterr_ff <= (rxd_s == `GMII_EXTEND_ERR_OCTET);
               rx_fc_ff     <= (rxd_s == `GMII_FALSE_CARRIER);
            end
         end
      end
   end

   assign rx_data          = rx_data_ff;
   assign rx_valid         = rx_valid_ff;
   assign rx_data_err      = rx_derr_ff;
   assign rx_sop           = rx_sop_ff;
   assign rx_eop           = rx_eop_ff;
   assign rx_frame_bad     = rx_bad_ff;
   assign rx_extend        = rx_ext_ff;
   assign rx_extend_err    = rx_exterr_ff;
   assign rx_false_carrier = rx_fc_ff;

endmodule // gmii_frame_stream

`default_nettype wire

// file: tb/gmii_frame_stream_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "gmii_frame_consts.vh"

module gmii_frame_stream_assertions
#(
   parameter JAM_OCTET = 8'h99
)
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       tx_busy,
   input wire logic [7:0] txd,
   input wire logic       tx_en,
   input wire logic       tx_er,
   input wire logic       crs,
   input wire logic       col,
   input wire logic       carrier_sense,
   input wire logic       collision,
   input wire logic       rx_eop,
   input wire logic       rx_frame_bad,
   input wire logic       rx_extend
);
   localparam int DET_MAX  = `GMII_DETECT_MAX_CYC;
   localparam int RESP_MAX = `GMII_RESPONSE_MAX_CYC;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // Four cycles is margin; the outputs go quiet in the same cycle as the state goes idle
   AST_IDLE_QUIET: assert property (!tx_busy [*4] |-> !tx_en && !tx_er)
      else $error("idle lines active");
   AST_PRE_FIRST: assert property ($rose(tx_en) |-> txd == `GMII_PREAMBLE_OCTET)
      else $error("no preamble first");
   AST_PRE_SFD: assert property ($rose(tx_en) |-> ##13 (tx_en && txd == `GMII_PREAMBLE_OCTET) ##1 (tx_en && txd == `GMII_SFD_OCTET))
      else $error("delimiter misplaced");
   AST_EXT_CODE: assert property (tx_er && !tx_en |-> txd == `GMII_EXTEND_OCTET)
      else $error("bad extend code");
   AST_COL_ON: assert property ($rose(col) |-> ##[1:DET_MAX] collision)
      else $error("collision rise late");
   AST_COL_OFF: assert property ($fell(col) |-> ##[1:DET_MAX] !collision)
      else $error("collision fall late");
   AST_CRS_ON: assert property ($rose(crs) |-> ##[1:DET_MAX] carrier_sense)
      else $error("carrier rise late");
   AST_CRS_OFF: assert property ($fell(crs) |-> ##[1:DET_MAX] !carrier_sense)
      else $error("carrier fall late");
   AST_JAM_TIME: assert property ($rose(col) && tx_en |-> ##[1:RESP_MAX] (tx_en && txd == JAM_OCTET))
      else $error("jam late");
   AST_BAD_AT_END: assert property (rx_frame_bad |-> rx_eop)
      else $error("bad flag without end");

   COV_TX: cover property ($rose(tx_en));
   COV_COL: cover property ($rose(collision));
   COV_EXT: cover property (rx_extend);
   COV_BAD: cover property (rx_frame_bad);
endmodule // gmii_frame_stream_assertions

bind gmii_frame_stream gmii_frame_stream_assertions #(.JAM_OCTET(JAM_OCTET)) chk_u
(
   .clk_sys, .reset_n, .tx_busy, .txd, .tx_en, .tx_er, .crs, .col,
   .carrier_sense, .collision, .rx_eop, .rx_frame_bad, .rx_extend
);
`default_nettype wire

// file: tb/gmii_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "gmii_frame_consts.vh"

module gmii_phy_model
(
   output logic       rx_clk,
   output logic [7:0] rxd,
   output logic       rx_dv,
   output logic       rx_er
);
   initial
   begin
      rx_clk = 1'b0;
      rxd = `GMII_IDLE_OCTET;
      rx_dv = 1'b0;
      rx_er = 1'b0;
   end

   // Clock runs only while octets are sent, so the block cannot lean on a free clock
   task octet(input logic dv, input logic er, input logic [7:0] d);
      begin
         rx_dv = dv;
         rx_er = er;
         rxd = d;
         #8 rx_clk = 1'b1;
         #16 rx_clk = 1'b0;
         #8;
      end
   endtask

   task idle(input int n);
      for (int i = 0; i < n; i++)
         octet(1'b0, 1'b0, `GMII_IDLE_OCTET);
   endtask

   task frame(input int npre, input int ndat, input int err_at, input int next,
              input logic [7:0] tail);
      begin
         idle(2);
         for (int i = 0; i < npre; i++)
            octet(1'b1, 1'b0, `GMII_PREAMBLE_OCTET);
         octet(1'b1, 1'b0, `GMII_SFD_OCTET);
         for (int i = 0; i < ndat; i++)
            octet(1'b1, i == err_at, 8'h10 + i[7:0]);
         for (int i = 0; i < next; i++)
            octet(1'b0, 1'b1, `GMII_EXTEND_OCTET);
         if (tail != 8'h00)
            octet(1'b0, 1'b1, tail);
         idle(3);
      end
   endtask
endmodule // gmii_phy_model
`default_nettype wire

// file: tb/gmii_frame_stream_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "gmii_frame_consts.vh"

module gmii_frame_stream_test;
   localparam logic [7:0] JAM_V = 8'h5A;
   logic       clk_sys, reset_n, tx_valid, tx_last, burst_en, crs, col;
   logic [7:0] tx_data, ext_octets;
   wire        tx_ready, tx_busy, tx_collided, gtx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er;
   wire  [7:0] txd, rxd, rx_data;
   wire        rx_valid, rx_data_err, rx_sop, rx_eop, rx_frame_bad, rx_extend;
   wire        rx_extend_err, rx_false_carrier, carrier_sense, collision;
   logic [9:0] txq[$];
   logic [7:0] rxq[$];
   int         err_count, checks_done, sop_n, eop_n, bad_n, ext_n, xerr_n, fc_n, derr_n, coll_n;

   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   gmii_frame_stream #(.JAM_OCTET(JAM_V)) dut_u
   (
      .clk_sys, .reset_n, .tx_valid, .tx_ready, .tx_data, .tx_last, .burst_en, .ext_octets,
      .tx_busy, .tx_collided, .gtx_clk, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv, .rx_er,
      .crs, .col, .rx_data, .rx_valid, .rx_data_err, .rx_sop, .rx_eop, .rx_frame_bad,
      .rx_extend, .rx_extend_err, .rx_false_carrier, .carrier_sense, .collision
   );
   gmii_phy_model phy_u (.rx_clk, .rxd, .rx_dv, .rx_er);

   always @(posedge gtx_clk)
      if (tx_en || tx_er)
         txq.push_back({tx_en, tx_er, txd});
   always @(posedge clk_sys)
   begin
      if (rx_valid === 1'b1)
         rxq.push_back(rx_data);
      sop_n += (rx_sop === 1'b1);
      eop_n += (rx_eop === 1'b1);
      bad_n += (rx_frame_bad === 1'b1);
      ext_n += (rx_extend === 1'b1);
      xerr_n += (rx_extend_err === 1'b1);
      fc_n += (rx_false_carrier === 1'b1);
      derr_n += (rx_valid === 1'b1 && rx_data_err === 1'b1);
      coll_n += (tx_collided === 1'b1);
   end

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         checks_done++;
         if (got !== exp)
         begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   task clr;
      @(negedge clk_sys);
      burst_en = 1'b0;
      txq.delete();
      rxq.delete();
      {sop_n, eop_n, bad_n, ext_n, xerr_n, fc_n, derr_n, coll_n} = '0;
   endtask

   task push(input logic [7:0] d, input logic l);
      int n;
      @(negedge clk_sys);
      tx_valid = 1'b1;
      tx_data = d;
      tx_last = l;
      n = 0;
      while (tx_ready !== 1'b1 && n < 2000)
      begin
         @(negedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
   endtask

   task release_tx;
      begin
         @(negedge clk_sys);
         tx_valid = 1'b0;
         tx_last = 1'b0;
      end
   endtask

   task wait_tx(input int n);
      int k;
      k = 0;
      while (txq.size() < n && k < 5000)
      begin
         @(posedge clk_sys);
         k++;
      end
      while (tx_busy !== 1'b0 && k < 10000)
      begin
         @(posedge clk_sys);
         k++;
      end
      repeat (8) @(posedge clk_sys);
   endtask

   task chk_pre(input int at);
      begin
         for (int i = 0; i < 7; i++)
            check("preamble", {2'b10, `GMII_PREAMBLE_OCTET}, txq[at+i]);
         check("delimiter", {2'b10, `GMII_SFD_OCTET}, txq[at+7]);
      end
   endtask

   task test_tx_frame;
      clr();
      ext_octets = 8'h02;
      crs = 1'b1;
      for (int i = 0; i < 4; i++)
         push(8'hA0 + i[7:0], 1'b0);
      release_tx();
      check("ready while full", 0, tx_ready);
      check("enable while deferring", 0, tx_en);
      crs = 1'b0;
      push(8'hA4, 1'b1);
      release_tx();
      wait_tx(15);
      check("octet count", 15, txq.size());
      chk_pre(0);
      for (int i = 0; i < 5; i++)
         check("data", {2'b10, 8'hA0 + i[7:0]}, txq[8+i]);
      for (int i = 0; i < 2; i++)
         check("extend", {2'b01, `GMII_EXTEND_OCTET}, txq[13+i]);
      $display("test tx_frame done");
   endtask

   task test_burst;
      clr();
      ext_octets = 8'h00;
      burst_en = 1'b1;
      crs = 1'b1;
      push(8'hB0, 1'b0);
      push(8'hB1, 1'b1);
      push(8'hC0, 1'b0);
      push(8'hC1, 1'b1);
      release_tx();
      crs = 1'b0;
      wait_tx(32);
      check("burst octets", 32, txq.size());
      chk_pre(0);
      chk_pre(22);
      check("data", {2'b10, 8'hB1}, txq[9]);
      check("data", {2'b10, 8'hC0}, txq[30]);
      for (int i = 0; i < 12; i++)
         check("burst gap", {2'b01, `GMII_EXTEND_OCTET}, txq[10+i]);
      $display("test burst done");
   endtask

   task test_collision;
      int n;
      clr();
      for (int i = 0; i < 4; i++)
         push(8'hA0 + i[7:0], i == 3);
      release_tx();
      n = 0;
      while (!(tx_en === 1'b1 && txd === `GMII_SFD_OCTET) && n < 2000)
      begin
         @(posedge gtx_clk);
         n++;
      end
      @(negedge clk_sys);
      col = 1'b1;
      n = 0;
      while (!(tx_en === 1'b1 && txd === JAM_V) && n < 40)
      begin
         @(posedge gtx_clk);
         n++;
      end
      check("jam delay ok", 1, n <= 14);
      wait_tx(13);
      @(negedge clk_sys);
      col = 1'b0;
      check("octets with jam", 13, txq.size());
      check("data before jam", {2'b10, 8'hA0}, txq[8]);
      for (int i = 9; i < 13; i++)
         check("jam", {2'b10, JAM_V}, txq[i]);
      check("collided pulses", 1, coll_n);
      repeat (20) @(posedge clk_sys);
      $display("test collision done");
   endtask

   task test_rx_pre;
      int pre[3];
      pre = '{0, 3, 7};
      foreach (pre[j])
      begin
         clr();
         phy_u.frame(pre[j], 3, -1, 0, 8'h00);
         repeat (12) @(posedge clk_sys);
         check("rx octets", 3, rxq.size());
         for (int i = 0; i < 3; i++)
            check("rx data", 8'h10 + i[7:0], rxq[i]);
         check("sop", 1, sop_n);
         check("eop", 1, eop_n);
         check("bad", 0, bad_n);
      end
      $display("test rx_preamble done");
   endtask

   task test_rx_err;
      clr();
      phy_u.frame(7, 3, 1, 2, `GMII_EXTEND_ERR_OCTET);
      phy_u.octet(1'b0, 1'b1, `GMII_FALSE_CARRIER);
      phy_u.idle(2);
      repeat (12) @(posedge clk_sys);
      check("rx octets", 3, rxq.size());
      check("data errors", 1, derr_n);
      check("bad", 1, bad_n);
      check("eop", 1, eop_n);
      check("extend seen", 1, ext_n > 0);
      check("extend error", 1, xerr_n);
      check("false carrier", 1, fc_n);
      $display("test rx_errors done");
   endtask

   initial
   begin
      {reset_n, tx_valid, tx_last, burst_en, crs, col} = '0;
      tx_data = 8'h00;
      ext_octets = 8'h00;
      err_count = 0;
      checks_done = 0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      reset_n = 1'b1;
      test_tx_frame();
      test_burst();
      test_collision();
      test_rx_pre();
      test_rx_err();
      finish_test();
   end

   initial
   begin
      #100000;
      err_count++;
      finish_test();
   end
endmodule // gmii_frame_stream_test
`default_nettype wire
